// [hw/spidbp_pkg.sv]
package spidbp_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int SPIDBP_DATA_W = 16;
  localparam int SPIDBP_FIFO_DEPTH = 4;
  localparam int SPIDBP_FILL_W = $clog2(SPIDBP_FIFO_DEPTH + 1);
  localparam int SPIDBP_ADDR_W = 16;
  localparam int SPIDBP_BRR_W = 7;
  localparam int SPIDBP_LEN_W = 4;
  localparam int SPIDBP_CNT_W = 5;
  localparam int SPIDBP_LVL_W = 5;
  localparam int SPIDBP_DIV_W = 8;

  // ----------------------------------------------------------------
  // register word addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] SPIDBP_ADDR_CFG = 16'h7040;
  localparam logic [15:0] SPIDBP_ADDR_OPCTL = 16'h7041;
  localparam logic [15:0] SPIDBP_ADDR_STATUS = 16'h7042;
  localparam logic [15:0] SPIDBP_ADDR_BRR = 16'h7044;
  localparam logic [15:0] SPIDBP_ADDR_MIRROR = 16'h7046;
  localparam logic [15:0] SPIDBP_ADDR_RXBUF = 16'h7047;
  localparam logic [15:0] SPIDBP_ADDR_TXBUF = 16'h7048;
  localparam logic [15:0] SPIDBP_ADDR_SHIFT = 16'h7049;
  localparam logic [15:0] SPIDBP_ADDR_FFTX = 16'h704A;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SPIDBP_CFG_POL = 6;
  localparam int SPIDBP_OPCTL_PHASE = 3;
  localparam int SPIDBP_OPCTL_MASTER = 2;
  localparam int SPIDBP_OPCTL_DRIVE = 1;
  localparam int SPIDBP_STS_DONE = 6;
  localparam int SPIDBP_STS_FULL = 5;
  localparam int SPIDBP_FFTX_CHRST = 15;
  localparam int SPIDBP_FFTX_ENA = 14;
  localparam int SPIDBP_FFTX_QRST = 13;
  localparam int SPIDBP_FFTX_FILL_LSB = 8;
  localparam int SPIDBP_FFTX_IFLAG = 7;
  localparam int SPIDBP_FFTX_ICLR = 6;
  localparam int SPIDBP_FFTX_IEN = 5;

  // ----------------------------------------------------------------
  // reset values and divider figures
  // ----------------------------------------------------------------
  localparam logic [15:0] SPIDBP_FFTX_RESET = 16'hA000;
  localparam logic [15:0] SPIDBP_WORD_RESET = 16'h0000;
  localparam logic [6:0] SPIDBP_DIV_MIN = 7'h03;
  localparam logic [7:0] SPIDBP_DIV_FIXED = 8'h04;

endpackage

// [hw/spidbp_stream_if.sv]
interface spidbp_stream_if #(
  parameter int W = 16
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );

  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface

// [hw/spidbp_fifo.sv]
module spidbp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic flush,
  spidbp_stream_if.snk in_s,
  spidbp_stream_if.src out_s,
  output logic [$clog2(DEPTH+1)-1:0] fill
);
  import spidbp_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } spidbp_fifo_st_t;

  spidbp_fifo_st_t s_reg;
  spidbp_fifo_st_t s_next;
  logic push;
  logic pop;

  assign in_s.ready = (s_reg.cnt != CW'(DEPTH));
  assign out_s.valid = (s_reg.cnt != '0);
  assign out_s.data = s_reg.mem[s_reg.rp];
  assign fill = s_reg.cnt;
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  always_comb begin
    s_next = s_reg;
    if (flush) begin
      s_next.wp = '0;
      s_next.rp = '0;
      s_next.cnt = '0;
    end else begin
      if (push) begin
        s_next.mem[s_reg.wp] = in_s.data;
        s_next.wp = (s_reg.wp == AW'(DEPTH - 1)) ? '0 : s_reg.wp + 1'b1;
      end
      if (pop) begin
        s_next.rp = (s_reg.rp == AW'(DEPTH - 1)) ? '0 : s_reg.rp + 1'b1;
      end
      case ({push, pop})
        2'b10: s_next.cnt = s_reg.cnt + 1'b1;
        2'b01: s_next.cnt = s_reg.cnt - 1'b1;
        default: s_next.cnt = s_reg.cnt;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// [hw/spidbp_clkdiv.sv]
module spidbp_clkdiv (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [spidbp_pkg::SPIDBP_BRR_W-1:0] divider,
  output logic lead_tick,
  output logic trail_tick,
  output logic phase_high
);
  import spidbp_pkg::*;

  typedef struct packed {
    logic [SPIDBP_DIV_W-1:0] cnt;
    logic high;
  } spidbp_div_st_t;

  spidbp_div_st_t s_reg;
  spidbp_div_st_t s_next;
  logic [SPIDBP_DIV_W-1:0] div;
  logic [SPIDBP_DIV_W-1:0] half;

  // low settings fall back to a fixed divide so the line never runs too fast
  assign div = (divider < SPIDBP_DIV_MIN) ? SPIDBP_DIV_FIXED : {1'b0, divider} + 8'h01;
  assign half = div >> 1;
  assign trail_tick = run & (s_reg.cnt == div - 8'h01);
  assign lead_tick = run & ~s_reg.high & (s_reg.cnt == half - 8'h01);
  assign phase_high = s_reg.high;

  always_comb begin
    s_next = s_reg;
    if (!run) begin
      s_next.cnt = '0;
      s_next.high = 1'b0;
    end else if (trail_tick) begin
      s_next.cnt = '0;
      s_next.high = 1'b0;
    end else begin
      s_next.cnt = s_reg.cnt + 8'h01;
      if (lead_tick) begin
        s_next.high = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// [hw/spidbp_top.sv]
// Behaviour
// - reading the receive holding word clears the character-done status flag.
// - a finished character is copied to the receive word and flags done together.
// - received characters land right-justified since bits enter at the bottom.
// - transmit write during an active transfer sets transmit-buffer-full.
// - at character end a full transmit buffer reloads the shifter and clears full.
// - transmit write while idle falls into the shifter, full stays clear.
// - in master mode an idle transmit write starts a transfer.
// - the shifter sends most significant bit first, one bit per serial clock.
// - each bit sent out is matched by one bit taken in at the bottom.
// - serial data pin is driven only while output drive enable is set.
// - master shift-word write starts a transfer using polarity and phase settings.
// - a dummy shift-word write in master mode runs a full receive sequence.
// - the FIFO transmit control word holds reset, enable, fill, flag and level fields.
// - receive holding word is a read-only 16-bit word resetting to zero.
// - reading the debug mirror returns receive data and keeps the done flag.
// - master serial clock is divider plus one, or four for small settings.
//
// The plain strobed port is this design's own decision.
module spidbp_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [spidbp_pkg::SPIDBP_ADDR_W-1:0] bus_addr,
  input wire logic [spidbp_pkg::SPIDBP_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [spidbp_pkg::SPIDBP_DATA_W-1:0] bus_rdata,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic tx_queue_ready
);
  import spidbp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // the two active-low reset fields are kept inverted so all state resets to zero
  typedef struct packed {
    logic cfg_pol;
    logic [SPIDBP_LEN_W-1:0] cfg_len;
    logic op_phase;
    logic op_master;
    logic op_drive;
    logic [SPIDBP_BRR_W-1:0] brr;
    logic [SPIDBP_DATA_W-1:0] rxbuf;
    logic [SPIDBP_DATA_W-1:0] txbuf;
    logic [SPIDBP_DATA_W-1:0] shift;
    logic tx_full;
    logic done;
    logic chan_hold;
    logic fifo_feature_enable;
    logic queue_hold;
    logic transmit_queue_irq_flag;
    logic transmit_queue_irq_enable;
    logic [SPIDBP_LVL_W-1:0] transmit_queue_trigger_level;
    logic running;
    logic loaded;
    logic [SPIDBP_CNT_W-1:0] bitcnt;
    logic sample;
    logic out_bit;
    logic sclk_prev;
    logic sclk_pin;
    logic data_pin;
    logic [SPIDBP_DATA_W-1:0] rdata;
  } spidbp_top_st_t;

  spidbp_top_st_t s_reg;
  spidbp_top_st_t s_next;

  // ----------------------------------------------------------------
  // transmit queue and clock divider
  // ----------------------------------------------------------------
  spidbp_stream_if #(.W(SPIDBP_DATA_W)) tx_in ();
  spidbp_stream_if #(.W(SPIDBP_DATA_W)) tx_out ();

  logic [SPIDBP_FILL_W-1:0] fill;
  logic queue_push;
  logic queue_pop;
  logic div_run;
  logic div_lead;
  logic div_trail;
  logic div_high;

  assign tx_in.valid = queue_push;
  assign tx_in.data = bus_wdata;
  assign tx_out.ready = queue_pop;
  assign tx_queue_ready = tx_in.ready;

  spidbp_fifo #(.W(SPIDBP_DATA_W), .DEPTH(SPIDBP_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .flush(s_reg.chan_hold | s_reg.queue_hold),
    .in_s(tx_in),
    .out_s(tx_out),
    .fill(fill)
  );

  assign div_run = s_reg.running & s_reg.op_master & ~s_reg.chan_hold;

  spidbp_clkdiv u_div (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(div_run),
    .divider(s_reg.brr),
    .lead_tick(div_lead),
    .trail_tick(div_trail),
    .phase_high(div_high)
  );

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign serial_clock_line_out = s_reg.sclk_pin;
  assign serial_clock_line_oe = s_reg.op_master;
  assign serial_data_out = s_reg.data_pin;
  assign serial_data_oe = s_reg.op_drive;
  assign bus_rdata = s_reg.rdata;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic lvl;
  logic lead;
  logic trail;
  logic in_bit;
  logic complete;
  logic busy_n;
  logic wr_tx;
  logic [SPIDBP_DATA_W-1:0] shifted;
  logic [SPIDBP_LVL_W-1:0] fill5;

  assign fill5 = SPIDBP_LVL_W'(fill);

  always_comb begin
    s_next = s_reg;
    queue_push = 1'b0;
    queue_pop = 1'b0;
    complete = 1'b0;
    shifted = {s_reg.shift[SPIDBP_DATA_W-2:0], 1'b0};
    in_bit = 1'b0;
    busy_n = 1'b0;
    wr_tx = bus_wr & (bus_addr == SPIDBP_ADDR_TXBUF);

    // edges away from and back to the idle level drive both roles alike
    lvl = serial_clock_line_in ^ s_reg.cfg_pol;
    s_next.sclk_prev = lvl;
    if (s_reg.op_master) begin
      lead = div_lead;
      trail = div_trail;
    end else begin
      lead = lvl & ~s_reg.sclk_prev;
      trail = ~lvl & s_reg.sclk_prev;
    end
    if (s_reg.chan_hold) begin
      lead = 1'b0;
      trail = 1'b0;
    end

    // ---- shift engine ----
    if (lead) begin
      if (s_reg.op_phase) begin
        s_next.out_bit = s_reg.shift[SPIDBP_DATA_W-1];
      end else begin
        s_next.sample = serial_data_in;
      end
    end
    if (trail) begin
      in_bit = s_reg.op_phase ? serial_data_in : s_reg.sample;
      shifted = {s_reg.shift[SPIDBP_DATA_W-2:0], in_bit};
      s_next.shift = shifted;
      s_next.bitcnt = s_reg.bitcnt + 5'h01;
      if (s_reg.bitcnt == {1'b0, s_reg.cfg_len}) begin
        complete = 1'b1;
      end
    end
    if (complete) begin
      s_next.rxbuf = shifted;
      s_next.bitcnt = '0;
      if (s_reg.fifo_feature_enable && tx_out.valid) begin
        s_next.shift = tx_out.data;
        queue_pop = 1'b1;
      end else if (!s_reg.fifo_feature_enable && s_reg.tx_full) begin
        s_next.shift = s_reg.txbuf;
        s_next.tx_full = 1'b0;
      end else begin
        s_next.running = 1'b0;
        s_next.loaded = 1'b0;
      end
    end

    // an idle channel with queued words starts on its own
    busy_n = s_next.running | (s_next.bitcnt != '0);
    if (!s_reg.chan_hold && s_reg.fifo_feature_enable && !busy_n && !s_next.loaded && tx_out.valid) begin
      s_next.shift = tx_out.data;
      s_next.loaded = 1'b1;
      s_next.running = s_reg.op_master;
      queue_pop = 1'b1;
      busy_n = s_reg.op_master;
    end

    // ---- register writes ----
    if (bus_wr) begin
      case (bus_addr)
        SPIDBP_ADDR_CFG: begin
          s_next.cfg_pol = bus_wdata[SPIDBP_CFG_POL];
          s_next.cfg_len = bus_wdata[SPIDBP_LEN_W-1:0];
        end
        SPIDBP_ADDR_OPCTL: begin
          s_next.op_phase = bus_wdata[SPIDBP_OPCTL_PHASE];
          s_next.op_master = bus_wdata[SPIDBP_OPCTL_MASTER];
          s_next.op_drive = bus_wdata[SPIDBP_OPCTL_DRIVE];
        end
        SPIDBP_ADDR_BRR: begin
          s_next.brr = bus_wdata[SPIDBP_BRR_W-1:0];
        end
        SPIDBP_ADDR_SHIFT: begin
          // a write into a running shifter would corrupt the character, so it is dropped
          if (!busy_n && !s_reg.chan_hold) begin
            s_next.shift = bus_wdata;
            s_next.loaded = 1'b1;
            s_next.running = s_reg.op_master;
          end
        end
        SPIDBP_ADDR_FFTX: begin
          s_next.chan_hold = ~bus_wdata[SPIDBP_FFTX_CHRST];
          s_next.fifo_feature_enable = bus_wdata[SPIDBP_FFTX_ENA];
          s_next.queue_hold = ~bus_wdata[SPIDBP_FFTX_QRST];
          s_next.transmit_queue_irq_enable = bus_wdata[SPIDBP_FFTX_IEN];
          s_next.transmit_queue_trigger_level = bus_wdata[SPIDBP_LVL_W-1:0];
          if (bus_wdata[SPIDBP_FFTX_ICLR]) begin
            s_next.transmit_queue_irq_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (wr_tx && !s_reg.chan_hold) begin
      if (s_reg.fifo_feature_enable) begin
        queue_push = 1'b1;
      end else if (busy_n) begin
        s_next.txbuf = bus_wdata;
        s_next.tx_full = 1'b1;
      end else begin
        s_next.txbuf = bus_wdata;
        s_next.shift = bus_wdata;
        s_next.loaded = 1'b1;
        s_next.running = s_reg.op_master;
      end
    end

    // set wins over the write-one clear
    if (fill5 <= s_reg.transmit_queue_trigger_level) begin
      s_next.transmit_queue_irq_flag = 1'b1;
    end

    // ---- register reads ----
    s_next.rdata = SPIDBP_WORD_RESET;
    if (bus_rd) begin
      case (bus_addr)
        SPIDBP_ADDR_CFG: begin
          s_next.rdata[SPIDBP_CFG_POL] = s_reg.cfg_pol;
          s_next.rdata[SPIDBP_LEN_W-1:0] = s_reg.cfg_len;
        end
        SPIDBP_ADDR_OPCTL: begin
          s_next.rdata[SPIDBP_OPCTL_PHASE] = s_reg.op_phase;
          s_next.rdata[SPIDBP_OPCTL_MASTER] = s_reg.op_master;
          s_next.rdata[SPIDBP_OPCTL_DRIVE] = s_reg.op_drive;
        end
        SPIDBP_ADDR_STATUS: begin
          s_next.rdata[SPIDBP_STS_DONE] = s_reg.done;
          s_next.rdata[SPIDBP_STS_FULL] = s_reg.tx_full;
        end
        SPIDBP_ADDR_BRR: begin
          s_next.rdata[SPIDBP_BRR_W-1:0] = s_reg.brr;
        end
        SPIDBP_ADDR_MIRROR: begin
          s_next.rdata = s_reg.rxbuf;
        end
        SPIDBP_ADDR_RXBUF: begin
          s_next.rdata = s_reg.rxbuf;
          s_next.done = 1'b0;
        end
        SPIDBP_ADDR_TXBUF: begin
          s_next.rdata = s_reg.txbuf;
        end
        SPIDBP_ADDR_SHIFT: begin
          s_next.rdata = s_reg.shift;
        end
        SPIDBP_ADDR_FFTX: begin
          s_next.rdata[SPIDBP_FFTX_CHRST] = ~s_reg.chan_hold;
          s_next.rdata[SPIDBP_FFTX_ENA] = s_reg.fifo_feature_enable;
          s_next.rdata[SPIDBP_FFTX_QRST] = ~s_reg.queue_hold;
          s_next.rdata[SPIDBP_FFTX_FILL_LSB +: SPIDBP_LVL_W] = fill5;
          s_next.rdata[SPIDBP_FFTX_IFLAG] = s_reg.transmit_queue_irq_flag;
          s_next.rdata[SPIDBP_FFTX_IEN] = s_reg.transmit_queue_irq_enable;
          s_next.rdata[SPIDBP_LVL_W-1:0] = s_reg.transmit_queue_trigger_level;
        end
        default: begin
        end
      endcase
    end

    // a completion in the same cycle as the clearing read keeps the flag
    if (complete) begin
      s_next.done = 1'b1;
    end

    // soft channel reset holds the shifter idle and drops pending state
    if (s_next.chan_hold) begin
      s_next.running = 1'b0;
      s_next.loaded = 1'b0;
      s_next.bitcnt = '0;
      s_next.tx_full = 1'b0;
      s_next.done = 1'b0;
    end

    // ---- registered pins ----
    if (s_reg.op_master && s_next.running) begin
      s_next.sclk_pin = s_reg.cfg_pol ^ (div_lead | (div_high & ~div_trail));
    end else begin
      s_next.sclk_pin = s_next.cfg_pol;
    end
    s_next.data_pin = s_next.op_phase ? s_next.out_bit : s_next.shift[SPIDBP_DATA_W-1];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// [verif/spidbp_top_sva.sv]
module spidbp_top_sva (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [spidbp_pkg::SPIDBP_ADDR_W-1:0] bus_addr,
  input wire logic [spidbp_pkg::SPIDBP_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [spidbp_pkg::SPIDBP_DATA_W-1:0] bus_rdata,
  input wire logic serial_clock_line_in,
  input wire logic serial_clock_line_out,
  input wire logic serial_clock_line_oe,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic tx_queue_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import spidbp_pkg::*;
  logic mapped;
  logic opw;
  assign mapped = bus_addr inside {SPIDBP_ADDR_CFG, SPIDBP_ADDR_OPCTL, SPIDBP_ADDR_STATUS, SPIDBP_ADDR_BRR,
    SPIDBP_ADDR_MIRROR, SPIDBP_ADDR_RXBUF, SPIDBP_ADDR_TXBUF, SPIDBP_ADDR_SHIFT, SPIDBP_ADDR_FFTX};
  assign opw = bus_wr && bus_addr == SPIDBP_ADDR_OPCTL;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
    else $error("read data present without a read");
  a_unmapped_zero: assert property (bus_rd && !mapped |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_drive_follow: assert property (opw |=> serial_data_oe == $past(bus_wdata[SPIDBP_OPCTL_DRIVE]))
    else $error("data drive enable does not follow control write");
  a_drive_hold: assert property (!opw |=> $stable(serial_data_oe))
    else $error("data drive enable moved without a control write");
  a_master_oe: assert property (opw |=> serial_clock_line_oe == $past(bus_wdata[SPIDBP_OPCTL_MASTER]))
    else $error("clock drive does not follow master bit");
  a_sclk_half: assert property (serial_clock_line_oe && !$stable(serial_clock_line_out) |=> $stable(serial_clock_line_out))
    else $error("serial clock half period shorter than two cycles");
  a_fftx_fields: assert property (bus_rd && bus_addr == SPIDBP_ADDR_FFTX |=>
    !bus_rdata[SPIDBP_FFTX_ICLR] && bus_rdata[12:8] <= SPIDBP_FIFO_DEPTH)
    else $error("queue control read shows bad clear bit or fill");
  a_mirror_keep: assert property (bus_rd && bus_addr == SPIDBP_ADDR_MIRROR ##1
    bus_rd && bus_addr == SPIDBP_ADDR_RXBUF |=> bus_rdata == $past(bus_rdata))
    else $error("mirror and receive word disagree");
  c_sclk_run: cover property ($rose(serial_clock_line_out));
  c_queue_full: cover property (!tx_queue_ready);
  c_mirror_pair: cover property (bus_rd && bus_addr == SPIDBP_ADDR_MIRROR ##1 bus_rd && bus_addr == SPIDBP_ADDR_RXBUF);
endmodule

// [verif/spidbp_remote_slave.sv]
module spidbp_remote_slave (
  input wire logic mclk,
  input wire logic sclk,
  input wire logic pol,
  input wire logic pha,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] got,
  output int got_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  logic [7:0] sr = 8'h00;
  logic armed = 1'b0;
  logic cap = 1'b0;
  logic sclk_q = 1'b0;
  logic last = 1'b0;
  int nb = 0;
  task push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // a released line shows the inverse of its last bit, so stale data never looks valid
  assign miso = armed ? sr[7] : ~last;
  always @(posedge mclk) begin
    sclk_q <= sclk;
    if (!armed && q.size() > 0) begin
      sr <= q.pop_front();
      armed <= 1'b1;
      nb <= 0;
    // edges are judged against the idle level; phase one takes data on the trailing edge
    end else if ((sclk ^ pol) && !(sclk_q ^ pol)) begin
      cap <= mosi;
    end else if (!(sclk ^ pol) && (sclk_q ^ pol) && armed) begin
      sr <= {sr[6:0], pha ? mosi : cap};
      last <= sr[7];
      nb <= nb + 1;
      if (nb == 7) begin
        got <= {sr[6:0], pha ? mosi : cap};
        got_cnt <= got_cnt + 1;
        nb <= 0;
        if (q.size() > 0) sr <= q.pop_front();
        else armed <= 1'b0;
      end
    end
  end
endmodule

// [verif/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import spidbp_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] bus_rdata, v;
  logic serial_clock_line_in, serial_clock_line_out, serial_clock_line_oe, sclk_q;
  logic serial_data_in, serial_data_out, serial_data_oe, mosi_w, tx_queue_ready;
  logic [7:0] got;
  logic ppol = 1'b0, ppha = 1'b0, slv_clk = 1'b0;
  logic [15:0] ra [5] = '{16'h7047, 16'h7048, 16'h7049, 16'h704A, 16'h7043};
  logic [15:0] re [5] = '{16'h0000, 16'h0000, 16'h0000, 16'hA080, 16'h0000};
  int got_cnt, per, pcnt, fail_count, cmp_count, base, i;
  initial forever #10 mclk = ~mclk;
  // a released clock line is driven by the bench as remote master; the data line has a pull-up
  assign serial_clock_line_in = serial_clock_line_oe ? serial_clock_line_out : slv_clk;
  assign mosi_w = serial_data_oe ? serial_data_out : 1'b1;
  spidbp_top dut (.mclk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .serial_clock_line_in,
    .serial_clock_line_out, .serial_clock_line_oe, .serial_data_in, .serial_data_out, .serial_data_oe, .tx_queue_ready);
  spidbp_remote_slave peer (.mclk, .sclk(serial_clock_line_in), .pol(ppol), .pha(ppha), .mosi(mosi_w),
    .miso(serial_data_in), .got, .got_cnt);
  always @(posedge mclk) begin
    sclk_q <= serial_clock_line_out;
    if (serial_clock_line_out && !sclk_q) begin
      per <= pcnt;
      pcnt <= 1;
    end else pcnt <= pcnt + 1;
  end
  // ----------------------------------------------------------------
  // bus access and checking
  // ----------------------------------------------------------------
  task close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [15:0] a);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask
  task rdc(input string nm, input logic [15:0] a, input logic [15:0] e);
    rd(a);
    chk(nm, e, v);
  endtask
  task flag(input string nm, input int b, input logic e);
    rd(SPIDBP_ADDR_STATUS);
    chk(nm, {15'h0000, e}, {15'h0000, v[b]});
  endtask
  task wait_done();
    for (int k = 0; k < 3000; k++) begin
      rd(SPIDBP_ADDR_STATUS);
      if (v[SPIDBP_STS_DONE] === 1'b1) break;
    end
    if (v[SPIDBP_STS_DONE] !== 1'b1) begin
      $display("[FAIL] done flag expected 1 seen %b", v[SPIDBP_STS_DONE]);
      fail_count++;
      close_out();
    end
  endtask
  task xfer(input logic [7:0] sb, input logic [15:0] a, input logic [15:0] w);
    peer.push(sb);
    wr(a, w);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    for (i = 0; i < 5; i++) rdc("reset value", ra[i], re[i]);
    wr(SPIDBP_ADDR_RXBUF, 16'h1234);
    rdc("receive word read-only", SPIDBP_ADDR_RXBUF, 16'h0000);
    wr(SPIDBP_ADDR_CFG, 16'h0007);
    wr(SPIDBP_ADDR_OPCTL, 16'h0006);
    wr(SPIDBP_ADDR_BRR, 16'h0001);
    xfer(8'h5A, SPIDBP_ADDR_SHIFT, 16'hA500);
    wait_done();
    rdc("mirror", SPIDBP_ADDR_MIRROR, 16'h005A);
    flag("done after mirror", SPIDBP_STS_DONE, 1'b1);
    @(posedge mclk);
    bus_addr <= SPIDBP_ADDR_MIRROR;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_addr <= SPIDBP_ADDR_RXBUF;
    #1 chk("mirror pair", 16'h005A, bus_rdata);
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 chk("receive word", 16'h005A, bus_rdata);
    flag("done after read", SPIDBP_STS_DONE, 1'b0);
    chk("remote byte", 16'h00A5, {8'h00, got});
    chk("period fixed divider", 16'h0004, 16'(per));
    wr(SPIDBP_ADDR_BRR, 16'h0009);
    xfer(8'h81, SPIDBP_ADDR_SHIFT, 16'h0000);
    wait_done();
    rdc("dummy receive", SPIDBP_ADDR_RXBUF, 16'h0081);
    chk("period divider", 16'h000A, 16'(per));
    peer.push(8'h11);
    xfer(8'h22, SPIDBP_ADDR_SHIFT, 16'h3300);
    wr(SPIDBP_ADDR_TXBUF, 16'h4400);
    flag("buffer full", SPIDBP_STS_FULL, 1'b1);
    wait_done();
    rdc("first of pair", SPIDBP_ADDR_RXBUF, 16'h0011);
    flag("full cleared", SPIDBP_STS_FULL, 1'b0);
    wait_done();
    rdc("reloaded char", SPIDBP_ADDR_RXBUF, 16'h0022);
    chk("reloaded remote", 16'h0044, {8'h00, got});
    xfer(8'h66, SPIDBP_ADDR_TXBUF, 16'h7700);
    flag("fall-through full", SPIDBP_STS_FULL, 1'b0);
    wait_done();
    rdc("fall-through rx", SPIDBP_ADDR_RXBUF, 16'h0066);
    chk("fall-through remote", 16'h0077, {8'h00, got});
    wr(SPIDBP_ADDR_OPCTL, 16'h0004);
    chk("drive enable off", 16'h0000, {15'h0000, serial_data_oe});
    xfer(8'h01, SPIDBP_ADDR_SHIFT, 16'h0000);
    wait_done();
    chk("undriven line", 16'h00FF, {8'h00, got});
    rdc("undriven rx", SPIDBP_ADDR_RXBUF, 16'h0001);
    ppol <= 1'b1;
    ppha <= 1'b1;
    wr(SPIDBP_ADDR_CFG, 16'h0047);
    wr(SPIDBP_ADDR_OPCTL, 16'h000E);
    xfer(8'hC3, SPIDBP_ADDR_SHIFT, 16'h9600);
    wait_done();
    rdc("phase one rx", SPIDBP_ADDR_RXBUF, 16'h00C3);
    chk("phase one remote", 16'h0096, {8'h00, got});
    chk("idle polarity", 16'h0001, {15'h0000, serial_clock_line_out});
    ppol <= 1'b0;
    ppha <= 1'b0;
    wr(SPIDBP_ADDR_CFG, 16'h0007);
    wr(SPIDBP_ADDR_OPCTL, 16'h0002);
    chk("slave clock drive", 16'h0000, {15'h0000, serial_clock_line_oe});
    xfer(8'h3C, SPIDBP_ADDR_SHIFT, 16'hC300);
    for (i = 0; i < 16; i++) begin
      repeat (4) @(posedge mclk);
      slv_clk <= ~slv_clk;
    end
    wait_done();
    rdc("slave rx", SPIDBP_ADDR_RXBUF, 16'h003C);
    chk("slave remote", 16'h00C3, {8'h00, got});
    wr(SPIDBP_ADDR_OPCTL, 16'h0006);
    wr(SPIDBP_ADDR_FFTX, 16'hE000);
    base = got_cnt;
    for (i = 0; i < 6; i++) begin
      if (i < 5) peer.push(8'(i));
      wr(SPIDBP_ADDR_TXBUF, {8'(i), 8'h00});
      if (i == 0) repeat (4) @(posedge mclk);
    end
    chk("queue ready", 16'h0000, {15'h0000, tx_queue_ready});
    rdc("queue full", SPIDBP_ADDR_FFTX, 16'hE480);
    wr(SPIDBP_ADDR_FFTX, 16'hE040);
    rdc("flag cleared", SPIDBP_ADDR_FFTX, 16'hE400);
    for (i = 0; i < 3000 && got_cnt < base + 5; i++) @(posedge mclk);
    chk("queued words sent", 16'h0005, 16'(got_cnt - base));
    chk("last queued", 16'h0004, {8'h00, got});
    rdc("queue drained", SPIDBP_ADDR_FFTX, 16'hE080);
    close_out();
  end
endmodule

bind spidbp_top spidbp_top_sva u_sva (.mclk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
  .serial_clock_line_in, .serial_clock_line_out, .serial_clock_line_oe, .serial_data_in, .serial_data_out,
  .serial_data_oe, .tx_queue_ready);
